// *** shared/bts_pkg.sv ***
// What this block does
// [RQ1] clear-skip test takes a 7-bit register address 0..127 and bit index 0..7
// [RQ2] top field 01, next field 10 decodes as clear-skip; skip when bit is zero
// [RQ3] top field 01, next field 11 decodes as set-skip; skip when bit is one
// [RQ4] a taken skip discards the prefetched instruction and runs a no-operation cycle
// [RQ5] one word; one cycle without skip, two cycles when the skip is taken
// [RQ6] no status flag, tested register or working register is ever written
//
// Purpose: shared constants and carriers for the bit-test-skip decoder
// Assumes: 14-bit instruction words, 8-bit data registers
// Notes:   field positions are named here once and used by name in the decoder; the bench packs words by concatenation
`default_nettype none
package bts_pkg;
   localparam int          INSTR_W       = 14;
   localparam int          ADDR_W        = 7;
   localparam int          BIDX_W        = 3;
   localparam int          DATA_W        = 8;
   // instruction field positions
   localparam int          TOP_MSB       = 13;
   localparam int          TOP_LSB       = 12;
   localparam int          SUB_MSB       = 11;
   localparam int          SUB_LSB       = 10;
   localparam int          BIDX_MSB      = 9;
   localparam int          BIDX_LSB      = 7;
   localparam int          ADDR_MSB      = 6;
   localparam int          ADDR_LSB      = 0;
   // field encodings
   localparam logic [1:0]  TOP_BIT_OPS   = 2'h1;
   localparam logic [1:0]  SUB_CLR_SKIP  = 2'h2;
   localparam logic [1:0]  SUB_SET_SKIP  = 2'h3;
   // instruction cycle counts
   localparam int          CYC_NO_SKIP   = 1;
   localparam int          CYC_SKIP      = 2;
   // reset values
   localparam logic [ADDR_W-1:0] ADDR_RST = 7'h00;

   typedef struct packed {
      logic               valid;
      logic [INSTR_W-1:0] word;
   } bts_instr_t;

   typedef struct packed {
      logic done;        // one-cycle pulse when the instruction retires
      logic flush;       // one-cycle pulse: discard the prefetched word
      logic no_op_cycle; // one-cycle pulse: the no_operation_cycle slot
   } bts_result_t;

   typedef struct packed {
      logic file_we;
      logic work_we;
      logic status_we;
   } bts_write_t;
endpackage
`default_nettype wire

// *** hw/bts_bit_select.sv ***
// Purpose: pick one bit of a register value and form the skip condition
// Assumes: purely combinational, same clock domain as its user
// Notes:   polarity high means skip when the bit reads one
`default_nettype none
module bts_bit_select #(
   parameter int DATA_W = 8,
   parameter int BIDX_W = 3
) (
   input  wire logic [DATA_W-1:0] data,
   input  wire logic [BIDX_W-1:0] bit_idx,
   input  wire logic              skip_on_one,
   output logic                   take_skip
);
   // compare the selected bit against the wanted polarity
   assign take_skip = (data[bit_idx] == skip_on_one);
endmodule
`default_nettype wire

// *** hw/bts_decode.sv ***
// Purpose: decode and execute the two bit-test-skip instructions
// Assumes: register file read is combinational on rf_addr, same clock
// Notes:   other opcodes are ignored here; the core must not issue while busy
`default_nettype none
module bts_decode #(
   parameter int DATA_W = bts_pkg::DATA_W
) (
   input  wire logic                          clk,
   input  wire logic                          sys_rst,
   input  wire bts_pkg::bts_instr_t           instr,
   input  wire logic [DATA_W-1:0]             rf_rdata,
   output logic                               busy,
   output logic [bts_pkg::ADDR_W-1:0]         rf_addr,
   output logic                               rf_rd_en,
   output bts_pkg::bts_result_t               result,
   output bts_pkg::bts_write_t                wr_en
);
   typedef enum logic [2:0] {
      BTS_IDLE = 3'b001,
      BTS_TEST = 3'b010,
      BTS_NOP  = 3'b100
   } bts_state_t;

   // recognise either skip form by its top two fields
   function automatic logic is_bit_skip(input logic [bts_pkg::INSTR_W-1:0] w);
      is_bit_skip = (w[bts_pkg::TOP_MSB:bts_pkg::TOP_LSB] == bts_pkg::TOP_BIT_OPS) &&
                    w[bts_pkg::SUB_MSB];
   endfunction

   bts_state_t                   state_ff;
   bts_state_t                   nxt_state;
   logic [bts_pkg::ADDR_W-1:0]   addr_ff;
   logic [bts_pkg::BIDX_W-1:0]   bidx_ff;
   logic                         pol_ff;
   logic                         rd_en_ff;
   logic                         busy_ff;
   logic                         done_ff;
   logic                         flush_ff;
   logic                         nop_ff;
   bts_pkg::bts_write_t          wr_ff;
   logic                         take;
   logic                         start;

   assign start = instr.valid && (state_ff == BTS_IDLE) && is_bit_skip(instr.word);

   // tested bit against polarity
   bts_bit_select #(
      .DATA_W (DATA_W),
      .BIDX_W (bts_pkg::BIDX_W)
   ) u_sel (
      .data        (rf_rdata),
      .bit_idx     (bidx_ff),
      .skip_on_one (pol_ff),
      .take_skip   (take)
   );

   // next state: a taken skip adds the no-operation slot
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         BTS_IDLE: begin
            if (start) begin
               nxt_state = BTS_TEST;
            end
         end
         BTS_TEST: begin
            nxt_state = take ? BTS_NOP : BTS_IDLE; // RQ5
         end
         BTS_NOP: begin
            nxt_state = BTS_IDLE;
         end
         default: begin
            nxt_state = BTS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_ff <= BTS_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // latch operands at decode; address and bit index are separate fields
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         addr_ff <= bts_pkg::ADDR_RST;
         bidx_ff <= 3'h0;
         pol_ff  <= 1'b0;
      end else if (start) begin
         addr_ff <= instr.word[bts_pkg::ADDR_MSB:bts_pkg::ADDR_LSB];   // RQ1
         bidx_ff <= instr.word[bts_pkg::BIDX_MSB:bts_pkg::BIDX_LSB];   // RQ1
         // low sub bit picks the polarity: 10 skips on zero, 11 on one
         pol_ff  <= (instr.word[bts_pkg::SUB_MSB:bts_pkg::SUB_LSB] == bts_pkg::SUB_SET_SKIP); // RQ2 RQ3
      end
   end

   // read strobe covers the single test cycle only
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rd_en_ff <= 1'b0;
      end else begin
         rd_en_ff <= start;
      end
   end

   // busy holds off the core until the instruction and any nop slot finish
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         busy_ff <= 1'b0;
      end else begin
         busy_ff <= (nxt_state != BTS_IDLE);
      end
   end

   // retire pulses; flush goes out with done so the prefetch is dropped in time
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         done_ff  <= 1'b0;
         flush_ff <= 1'b0;
      end else begin
         done_ff  <= (state_ff == BTS_TEST);
         flush_ff <= (state_ff == BTS_TEST) && take; // RQ4
      end
   end

   // the slot the discarded word would have used becomes a no_operation_cycle
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         nop_ff <= 1'b0;
      end else begin
         nop_ff <= (state_ff == BTS_NOP); // RQ4
      end
   end

   // write enables kept low: a test never touches flags, file or working reg
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wr_ff <= '0;
      end else begin
         wr_ff <= '0; // RQ6
      end
   end

   assign busy               = busy_ff;
   assign rf_addr            = addr_ff;
   assign rf_rd_en           = rd_en_ff;
   assign result.done        = done_ff;
   assign result.flush       = flush_ff;
   assign result.no_op_cycle = nop_ff;
   assign wr_en              = wr_ff;

   // checks on decode, retire and no-operation timing
   // the skip encodings are decoded again here, apart from the function above
   logic                         is_skip_word;
   assign is_skip_word = (instr.word[bts_pkg::TOP_MSB:bts_pkg::TOP_LSB] == bts_pkg::TOP_BIT_OPS) &&
                         ((instr.word[bts_pkg::SUB_MSB:bts_pkg::SUB_LSB] == bts_pkg::SUB_CLR_SKIP) ||
                          (instr.word[bts_pkg::SUB_MSB:bts_pkg::SUB_LSB] == bts_pkg::SUB_SET_SKIP));

   sequence s_start;
      start;
   endsequence
   sequence s_nop_slot;
      nop_ff ##1 !nop_ff;
   endsequence
   sequence s_read;
      rd_en_ff && (state_ff == BTS_TEST);
   endsequence

   AST_ADDR_FIELD: assert property (@(posedge clk) disable iff (sys_rst) // RQ1
      start |=> (addr_ff == $past(instr.word[bts_pkg::ADDR_MSB:bts_pkg::ADDR_LSB])) &&
                (bidx_ff == $past(instr.word[bts_pkg::BIDX_MSB:bts_pkg::BIDX_LSB])))
      else $error("address or bit index not captured from the word");

   // a skip word reaching an idle decoder is taken at once
   AST_ACCEPT_SKIP_WORD: assert property (@(posedge clk) disable iff (sys_rst) // RQ2 RQ3
      instr.valid && !busy_ff && is_skip_word |=> rd_en_ff && busy_ff)
      else $error("skip word not taken while idle");

   // any other word, or any word while busy, leaves the read port quiet
   AST_IGNORE_OTHER: assert property (@(posedge clk) disable iff (sys_rst) // RQ2 RQ3
      (!instr.valid || busy_ff || !is_skip_word) |=> !rd_en_ff)
      else $error("word taken that should have been ignored");

   AST_CLR_SKIP: assert property (@(posedge clk) disable iff (sys_rst) // RQ2
      s_read ##0 (!pol_ff && !rf_rdata[bidx_ff]) |=> flush_ff)
      else $error("clear-skip did not skip on a zero bit");

   AST_SET_SKIP: assert property (@(posedge clk) disable iff (sys_rst) // RQ3
      s_read ##0 (pol_ff && rf_rdata[bidx_ff]) |=> flush_ff)
      else $error("set-skip did not skip on a one bit");

   AST_NO_FALSE_SKIP: assert property (@(posedge clk) disable iff (sys_rst) // RQ2
      s_read ##0 (rf_rdata[bidx_ff] != pol_ff) |=> done_ff && !flush_ff ##1 !nop_ff)
      else $error("skip taken against the tested bit");

   AST_NOP_AFTER_FLUSH: assert property (@(posedge clk) disable iff (sys_rst) // RQ4
      flush_ff |=> s_nop_slot)
      else $error("flush not followed by exactly one nop cycle");

   // flush never stands without the retire pulse
   AST_FLUSH_WITH_DONE: assert property (@(posedge clk) disable iff (sys_rst) // RQ4
      flush_ff |-> done_ff)
      else $error("flush without done");

   // the read strobe is a single-cycle pulse
   AST_RD_ONE_CYCLE: assert property (@(posedge clk) disable iff (sys_rst) // RQ5
      rd_en_ff |=> !rd_en_ff)
      else $error("read strobe stood for more than one cycle");

   AST_CYCLES_NO_SKIP: assert property (@(posedge clk) disable iff (sys_rst) // RQ5
      s_start ##1 (rf_rdata[bidx_ff] != pol_ff) |=> !busy_ff && done_ff)
      else $error("unskipped test took more than one cycle");

   AST_CYCLES_SKIP: assert property (@(posedge clk) disable iff (sys_rst) // RQ5
      s_start ##1 (rf_rdata[bidx_ff] == pol_ff) |=> busy_ff ##1 !busy_ff && nop_ff)
      else $error("skipped test did not take two cycles");

   AST_NO_WRITES: assert property (@(posedge clk) disable iff (sys_rst) // RQ6
      (state_ff != BTS_IDLE) |-> (wr_en == '0) ##1 (wr_en == '0))
      else $error("a bit test raised a write enable");
endmodule
`default_nettype wire

// *** verif/bts_decode_test.sv ***
// Purpose: self-checking bench for the bit-test-skip decoder
// Assumes: one 125 MHz clock, synchronous active-high reset
// Notes:   inputs change 1 ns after the rising edge; random mix with corner cases
`default_nettype none
module bts_decode_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic                 clk = 1'b0;
   logic                 sys_rst = 1'b1;
   bts_pkg::bts_instr_t  instr = '0;
   logic [7:0]           rf_rdata = 8'h00;
   logic                 busy;
   logic [6:0]           rf_addr;
   logic                 rf_rd_en;
   bts_pkg::bts_result_t result;
   bts_pkg::bts_write_t  wr_en;
   int                   mismatches = 0;
   int                   checks_done = 0;
   logic [6:0]           last_addr = 7'h00;

   bts_decode bts_decode_inst (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .instr    (instr),
      .rf_rdata (rf_rdata),
      .busy     (busy),
      .rf_addr  (rf_addr),
      .rf_rd_en (rf_rd_en),
      .result   (result),
      .wr_en    (wr_en)
   );

   // free-running clock, 8 ns period
   always #4 clk = ~clk;

   task automatic step();
      @(posedge clk);
      #1;
   endtask

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
      checks_done++;
      if (s !== e) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic end_sim();
      $display("mismatches %0d checks_done %0d", mismatches, checks_done);
      if (mismatches == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // one instruction; a second word while busy must be dropped
   task automatic run_one(input logic [1:0] top, input logic [1:0] sub, input logic [2:0] b,
                          input logic [6:0] a, input logic [7:0] d);
      logic acc;
      logic skp;
      acc = (top === bts_pkg::TOP_BIT_OPS) && sub[1];
      skp = acc && (d[b] === (sub === bts_pkg::SUB_SET_SKIP));
      instr = {1'b1, top, sub, b, a};
      step();
      instr = {acc, 2'h1, 2'h3, ~b, ~a}; // only sent while busy, never when idle
      rf_rdata = d;
      if (acc) last_addr = a;
      chk("rf_rd_en", {7'h0, acc}, {7'h0, rf_rd_en});
      chk("rf_addr", {1'h0, last_addr}, {1'h0, rf_addr});
      chk("busy_c1", {7'h0, acc}, {7'h0, busy});
      step();
      instr = '0;
      rf_rdata = ~d; // stale data must not matter after the read edge
      chk("done", {7'h0, acc}, {7'h0, result.done});
      chk("flush", {7'h0, skp}, {7'h0, result.flush});
      chk("busy_c2", {7'h0, skp}, {7'h0, busy});
      chk("rd_en_again", 8'h00, {7'h0, rf_rd_en});
      chk("wr_en", 8'h00, {5'h0, wr_en});
      step();
      chk("no_op_cycle", {7'h0, skp}, {7'h0, result.no_op_cycle});
      chk("busy_c3", 8'h00, {7'h0, busy});
      chk("done_c3", 8'h00, {7'h0, result.done});
      chk("rf_addr_hold", {1'h0, last_addr}, {1'h0, rf_addr});
      chk("wr_en_c3", 8'h00, {5'h0, wr_en});
   endtask

   // watchdog: the full run needs about 864 cycles
   initial begin
      #50000;
      mismatches++;
      end_sim();
   end

   initial begin
      logic [7:0] one_hot;
      void'($urandom(32'h83E8));
      repeat (16) step();
      chk("rst_out", 8'h00, {busy, rf_rd_en, result, wr_en});
      sys_rst = 1'b0;
      // every bit index, both polarities, both opcodes, address extremes
      for (int b = 0; b < 8; b++) begin
         one_hot = 8'h01 << b;
         run_one(2'h1, bts_pkg::SUB_CLR_SKIP, b[2:0], 7'h7F, one_hot);
         run_one(2'h1, bts_pkg::SUB_CLR_SKIP, b[2:0], 7'h00, ~one_hot);
         run_one(2'h1, bts_pkg::SUB_SET_SKIP, b[2:0], 7'h7F, one_hot);
         run_one(2'h1, bts_pkg::SUB_SET_SKIP, b[2:0], 7'h00, ~one_hot);
      end
      // reset in mid-instruction must clear every output, the address too
      instr = {1'b1, 2'h1, bts_pkg::SUB_SET_SKIP, 3'h0, 7'h55};
      step();
      instr = '0;
      sys_rst = 1'b1;
      step();
      chk("rst_mid", 8'h00, {busy, rf_rd_en, result, wr_en});
      chk("rst_addr", 8'h00, {1'h0, rf_addr});
      sys_rst = 1'b0;
      last_addr = 7'h00;
      // random mix, including bit set/clear and other opcodes that are ignored
      repeat (250) begin
         run_one(2'($urandom_range(3, 0)), 2'($urandom_range(3, 0)), 3'($urandom_range(7, 0)),
                 7'($urandom_range(127, 0)), 8'($urandom_range(255, 0)));
      end
      end_sim();
   end
endmodule
`default_nettype wire
